// File: rtl/swu_params.svh
`ifndef SWU_PARAMS_SVH
`define SWU_PARAMS_SVH

// Clock and baud limits
`define SWU_CLK_HZ          125000000
`define SWU_MIN_BAUD        9000
`define SWU_MAX_BIT_CYC     (`SWU_CLK_HZ / `SWU_MIN_BAUD)
`define SWU_MIN_BIT_CYC     16

// Frame layout
`define SWU_SYNC_BYTE       8'h05
`define SWU_REPLY_ADDR      8'hFF
`define SWU_CRC_POLY        8'h07
`define SWU_RW_BIT          7
`define SWU_WR_LAST         3'h7
`define SWU_RD_LAST         3'h3
`define SWU_STOP_BIT        4'h8
`define SWU_TX_DONE_BIT     4'h9

// Sync measurement: falls seen before the closing one, bits spanned, bits left
`define SWU_SYNC_FALLS      2'h1
`define SWU_SYNC_BITS       4
`define SWU_SYNC_REST_BITS  5

// Timing in bit times or clock cycles
`define SWU_GLITCH_CYC      16
`define SWU_TIMEOUT_BITS    63
`define SWU_RECOVER_BITS    12
`define SWU_RELEASE_BITS    4
`define SWU_DELAY_STEP_BITS 8

// Host defaults
`define SWU_HOST_BIT_CYC    500
`define SWU_HOST_REPLY_BITS 256

`endif

// File: rtl/swu_pkg.sv
`include "swu_params.svh"

package swu_pkg;

  typedef enum logic [8:0] {
    D_IDLE    = 9'h001,
    D_SYNC    = 9'h002,
    D_SKIP    = 9'h004,
    D_WAITS   = 9'h008,
    D_DATA    = 9'h010,
    D_RECOVER = 9'h020,
    D_TURN    = 9'h040,
    D_SEND    = 9'h080,
    D_HOLD    = 9'h100
  } swu_dev_state_e;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_GUARD = 5'h02,
    H_SEND  = 5'h04,
    H_WAIT  = 5'h08,
    H_RECV  = 5'h10
  } swu_host_state_e;

  // Byte idx of a datagram whose CRC sits at index last
  function automatic logic [7:0] frame_byte(input logic [2:0]  idx,
                                            input logic [2:0]  last,
                                            input logic [7:0]  addr,
                                            input logic [7:0]  rw_reg,
                                            input logic [31:0] data,
                                            input logic [7:0]  crc);
    logic [7:0] b;
    if (idx == last) begin
      b = crc;
    end else begin
      case (idx)
        3'h0:    b = `SWU_SYNC_BYTE;
        3'h1:    b = addr;
        3'h2:    b = rw_reg;
        default: b = data[8 * (6 - int'(idx)) +: 8];
      endcase
    end
    return b;
  endfunction : frame_byte

endpackage : swu_pkg

// File: rtl/swu_if.sv
`timescale 1ns/1ns

interface swu_if;
  logic dev_tx;
  logic dev_oe;
  logic host_tx;
  logic host_oe;
  logic line;

  // Pulled high; any enabled driver sending low wins
  assign line = (~dev_oe | dev_tx) & (~host_oe | host_tx);

  modport dev  (input line, output dev_tx, output dev_oe);
  modport host (input line, output host_tx, output host_oe);
endinterface : swu_if

// File: rtl/swu_crc8.sv
`timescale 1ns/1ns
`include "swu_params.svh"

module swu_crc8 (
  // Running value and next byte
  input  wire logic [7:0] i_crc,
  input  wire logic [7:0] i_data,
  // Updated value
  output logic      [7:0] o_crc
);
  always_comb begin
    o_crc = i_crc;
    for (int j = 0; j < 8; j++) begin
      if (o_crc[7] ^ i_data[j]) begin
        o_crc = {o_crc[6:0], 1'b0} ^ `SWU_CRC_POLY;
      end else begin
        o_crc = {o_crc[6:0], 1'b0};
      end
    end
  end
endmodule : swu_crc8

// File: rtl/swu_device.sv
`timescale 1ns/1ns
`include "swu_params.svh"

module swu_device #(
  parameter int BT_W = 14
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Single-wire link
  swu_if.dev               bus,
  // Unit select and turnaround setting
  input  wire logic        i_addr_select_pin_low,
  input  wire logic        i_addr_select_pin_high,
  input  wire logic [3:0]  i_reply_turnaround_delay,
  // Register bank write
  output logic             o_wr_strobe,
  output logic      [6:0]  o_wr_addr,
  output logic      [31:0] o_wr_data,
  // Register bank read
  output logic             o_rd_strobe,
  output logic      [6:0]  o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  // Status
  output logic      [7:0]  o_write_count,
  output logic             o_rx_error
);
  localparam int TW = BT_W + 7;

  if ((1 << BT_W) <= `SWU_MAX_BIT_CYC) begin : g_chk
    $error("BT_W too narrow for the slowest baud rate");
  end

  swu_pkg::swu_dev_state_e state_ff;
  logic                    line_d_ff;
  logic [TW-1:0]           cnt_ff;
  logic [TW-1:0]           tmo_ff;
  logic [BT_W-1:0]         bt_ff;
  logic [BT_W-1:0]         good_bt_ff;
  logic [1:0]              falls_ff;
  logic [3:0]              bitn_ff;
  logic [2:0]              idx_ff;
  logic [7:0]              sh_ff;
  logic [7:0]              addr_ff;
  logic [7:0]              reg_ff;
  logic [7:0]              crc_ff;
  logic [7:0]              wcnt_ff;
  logic [31:0]             data_ff;
  logic [8:0]              tx_sh_ff;
  logic                    tx_ff;
  logic                    oe_ff;
  logic                    wr_ff;
  logic                    rd_ff;
  logic                    err_ff;

  wire            fall     = line_d_ff & ~bus.line;
  wire            rise     = ~line_d_ff & bus.line;
  wire            tick     = (cnt_ff == '0);
  wire [TW-1:0]   bt4      = cnt_ff + 1'b1;
  wire [BT_W-1:0] bt_meas  = BT_W'((bt4 + TW'(2)) / TW'(`SWU_SYNC_BITS));
  wire [TW-1:0]   meas_w   = TW'(bt_meas);
  wire [TW-1:0]   bt_w     = TW'(bt_ff);
  wire [TW-1:0]   half_w   = TW'(bt_ff >> 1);
  wire [TW-1:0]   good_w   = TW'(good_bt_ff);
  wire            tmo_hit  = tmo_ff > TW'(`SWU_TIMEOUT_BITS) * good_w;
  wire            rec_done = cnt_ff >= TW'(`SWU_RECOVER_BITS) * good_w;
  wire [7:0]      my_addr  = {6'h00, i_addr_select_pin_high, i_addr_select_pin_low};
  wire [2:0]      last_idx = reg_ff[`SWU_RW_BIT] ? `SWU_WR_LAST : `SWU_RD_LAST;
  wire            in_turn  = (state_ff == swu_pkg::D_TURN);
  wire            is_sync  = (state_ff == swu_pkg::D_SKIP);
  wire [2:0]      tx_idx   = in_turn ? 3'h0 : idx_ff + 3'h1;
  wire [TW-1:0]   delay_w  = TW'(`SWU_DELAY_STEP_BITS)
                             * TW'({1'b0, i_reply_turnaround_delay} + 5'h01) * bt_w;
  wire [7:0]      tx_byte;
  wire [7:0]      crc_in;
  wire [7:0]      crc_dat;
  wire [7:0]      crc_new;

  assign tx_byte = swu_pkg::frame_byte(tx_idx, `SWU_WR_LAST, `SWU_REPLY_ADDR,
                                       {1'b0, reg_ff[6:0]}, data_ff, crc_ff);
  assign crc_in  = is_sync ? 8'h00 : crc_ff;
  assign crc_dat = is_sync ? `SWU_SYNC_BYTE
                 : (state_ff == swu_pkg::D_DATA) ? sh_ff : tx_byte;

  swu_crc8 u_crc (
    .i_crc  (crc_in),
    .i_data (crc_dat),
    .o_crc  (crc_new)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff   <= swu_pkg::D_IDLE;
      line_d_ff  <= 1'b1;
      cnt_ff     <= '0;
      tmo_ff     <= '0;
      bt_ff      <= '0;
      good_bt_ff <= '1;
      falls_ff   <= 2'h0;
      bitn_ff    <= 4'h0;
      idx_ff     <= 3'h0;
      sh_ff      <= 8'h00;
      addr_ff    <= 8'h00;
      reg_ff     <= 8'h00;
      crc_ff     <= 8'h00;
      wcnt_ff    <= 8'h00;
      data_ff    <= 32'h0000_0000;
      tx_sh_ff   <= 9'h1FF;
      tx_ff      <= 1'b1;
      oe_ff      <= 1'b0;
      wr_ff      <= 1'b0;
      rd_ff      <= 1'b0;
      err_ff     <= 1'b0;
    end else begin
      line_d_ff <= bus.line;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      err_ff    <= 1'b0;
      if (tmo_ff != '1) begin
        tmo_ff <= tmo_ff + 1'b1;
      end
      if (!tick) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      case (state_ff)
        swu_pkg::D_IDLE: begin
          if (fall) begin
            cnt_ff   <= '0;
            tmo_ff   <= '0;
            falls_ff <= 2'h0;
            state_ff <= swu_pkg::D_SYNC;
          end
        end
        swu_pkg::D_SYNC: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (tmo_hit) begin
            state_ff <= swu_pkg::D_IDLE;
          end else if (rise && falls_ff == 2'h0 && cnt_ff < TW'(`SWU_GLITCH_CYC - 1)) begin
            cnt_ff   <= '0;
            err_ff   <= 1'b1;
            state_ff <= swu_pkg::D_RECOVER;
          end else if (fall && falls_ff == `SWU_SYNC_FALLS) begin
            bt_ff    <= bt_meas;
            cnt_ff   <= TW'(`SWU_SYNC_REST_BITS) * meas_w + (meas_w >> 1) - 1'b1;
            state_ff <= swu_pkg::D_SKIP;
          end else if (fall) begin
            falls_ff <= falls_ff + 2'h1;
          end
        end
        swu_pkg::D_SKIP: begin
          // Reserved bits of the sync byte are not sampled
          if (tick && bus.line) begin
            crc_ff   <= crc_new;
            idx_ff   <= 3'h1;
            state_ff <= swu_pkg::D_WAITS;
          end else if (tick) begin
            err_ff   <= 1'b1;
            state_ff <= swu_pkg::D_RECOVER;
          end
        end
        swu_pkg::D_WAITS: begin
          if (fall) begin
            tmo_ff   <= '0;
            cnt_ff   <= bt_w + half_w - 1'b1;
            bitn_ff  <= 4'h0;
            state_ff <= swu_pkg::D_DATA;
          end else if (tmo_hit) begin
            state_ff <= swu_pkg::D_IDLE;
          end
        end
        swu_pkg::D_DATA: begin
          if (tick) begin
            if (bitn_ff != `SWU_STOP_BIT) begin
              sh_ff   <= {bus.line, sh_ff[7:1]};
              bitn_ff <= bitn_ff + 4'h1;
              cnt_ff  <= bt_w - 1'b1;
            end else if (!bus.line) begin
              cnt_ff   <= '0;
              err_ff   <= 1'b1;
              state_ff <= swu_pkg::D_RECOVER;
            end else if (idx_ff >= 3'h3 && idx_ff == last_idx) begin
              if (sh_ff != crc_ff) begin
                cnt_ff   <= '0;
                err_ff   <= 1'b1;
                state_ff <= swu_pkg::D_RECOVER;
              end else begin
                good_bt_ff <= bt_ff;
                state_ff   <= swu_pkg::D_IDLE;
                if (addr_ff == my_addr && reg_ff[`SWU_RW_BIT]) begin
                  wr_ff   <= 1'b1;
                  wcnt_ff <= wcnt_ff + 8'h01;
                end else if (addr_ff == my_addr) begin
                  rd_ff    <= 1'b1;
                  crc_ff   <= 8'h00;
                  cnt_ff   <= delay_w - 1'b1;
                  state_ff <= swu_pkg::D_TURN;
                end
              end
            end else begin
              crc_ff   <= crc_new;
              idx_ff   <= idx_ff + 3'h1;
              state_ff <= swu_pkg::D_WAITS;
              if (idx_ff == 3'h1) begin
                addr_ff <= sh_ff;
              end else if (idx_ff == 3'h2) begin
                reg_ff <= sh_ff;
              end else begin
                data_ff <= {data_ff[23:0], sh_ff};
              end
            end
          end
        end
        swu_pkg::D_RECOVER: begin
          // Any low restarts the idle wait
          if (!bus.line) begin
            cnt_ff <= '0;
          end else if (rec_done) begin
            state_ff <= swu_pkg::D_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        swu_pkg::D_TURN: begin
          if (tick) begin
            data_ff  <= i_rd_data;
            tx_ff    <= 1'b0;
            oe_ff    <= 1'b1;
            tx_sh_ff <= {1'b1, tx_byte};
            crc_ff   <= crc_new;
            idx_ff   <= tx_idx;
            bitn_ff  <= 4'h0;
            cnt_ff   <= bt_w - 1'b1;
            state_ff <= swu_pkg::D_SEND;
          end
        end
        swu_pkg::D_SEND: begin
          if (tick && bitn_ff != `SWU_TX_DONE_BIT) begin
            tx_ff    <= tx_sh_ff[0];
            tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
            bitn_ff  <= bitn_ff + 4'h1;
            cnt_ff   <= bt_w - 1'b1;
          end else if (tick && idx_ff == `SWU_WR_LAST) begin
            cnt_ff   <= TW'(`SWU_RELEASE_BITS) * bt_w - 1'b1;
            state_ff <= swu_pkg::D_HOLD;
          end else if (tick) begin
            tx_ff    <= 1'b0;
            tx_sh_ff <= {1'b1, tx_byte};
            crc_ff   <= crc_new;
            idx_ff   <= tx_idx;
            bitn_ff  <= 4'h0;
            cnt_ff   <= bt_w - 1'b1;
          end
        end
        swu_pkg::D_HOLD: begin
          if (tick) begin
            oe_ff    <= 1'b0;
            state_ff <= swu_pkg::D_IDLE;
          end
        end
        default: begin
          state_ff <= swu_pkg::D_IDLE;
        end
      endcase
    end
  end

  assign bus.dev_tx    = tx_ff;
  assign bus.dev_oe    = oe_ff;
  assign o_wr_strobe   = wr_ff;
  assign o_wr_addr     = reg_ff[6:0];
  assign o_wr_data     = data_ff;
  assign o_rd_strobe   = rd_ff;
  assign o_rd_addr     = reg_ff[6:0];
  assign o_write_count = wcnt_ff;
  assign o_rx_error    = err_ff;
endmodule : swu_device

// File: rtl/swu_host.sv
`timescale 1ns/1ns
`include "swu_params.svh"

module swu_host #(
  parameter int BIT_CYC    = `SWU_HOST_BIT_CYC,
  parameter int REPLY_BITS = `SWU_HOST_REPLY_BITS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Single-wire link
  swu_if.host              bus,
  // Request
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_unit_addr,
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic [31:0] i_wr_data,
  output logic             o_busy,
  // Answer
  output logic             o_rd_valid,
  output logic      [31:0] o_rd_data,
  output logic             o_rd_error
);
  localparam int TW = $clog2(BIT_CYC * REPLY_BITS) + 2;
  localparam logic [TW-1:0] BIT_W = TW'(BIT_CYC);

  if (BIT_CYC < `SWU_MIN_BIT_CYC || BIT_CYC > `SWU_MAX_BIT_CYC) begin : g_chk
    $error("BIT_CYC outside the legal baud range");
  end

  swu_pkg::swu_host_state_e state_ff;
  logic                     line_d_ff;
  logic [TW-1:0]            cnt_ff;
  logic [3:0]               bitn_ff;
  logic [2:0]               idx_ff;
  logic [7:0]               sh_ff;
  logic [8:0]               tx_sh_ff;
  logic [7:0]               crc_ff;
  logic [7:0]               unit_ff;
  logic [7:0]               rw_ff;
  logic [31:0]              data_ff;
  logic [31:0]              rd_data_ff;
  logic                     bad_ff;
  logic                     tx_ff;
  logic                     oe_ff;
  logic                     valid_ff;
  logic                     err_ff;

  wire          idle    = (state_ff == swu_pkg::H_IDLE);
  wire          fall    = line_d_ff & ~bus.line;
  wire          tick    = (cnt_ff == '0);
  wire [2:0]    last    = rw_ff[`SWU_RW_BIT] ? `SWU_WR_LAST : `SWU_RD_LAST;
  wire [2:0]    nidx    = idle ? 3'h0 : idx_ff + 3'h1;
  wire [TW-1:0] guard_w = TW'(`SWU_RECOVER_BITS) * BIT_W - 1'b1;
  wire [7:0]    tx_byte;
  wire [7:0]    crc_new;

  assign tx_byte = swu_pkg::frame_byte(nidx, last, unit_ff, rw_ff, data_ff, crc_ff);

  swu_crc8 u_crc (
    .i_crc  (idle ? 8'h00 : crc_ff),
    .i_data ((state_ff == swu_pkg::H_RECV) ? sh_ff : tx_byte),
    .o_crc  (crc_new)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff   <= swu_pkg::H_IDLE;
      line_d_ff  <= 1'b1;
      cnt_ff     <= '0;
      bitn_ff    <= 4'h0;
      idx_ff     <= 3'h0;
      sh_ff      <= 8'h00;
      tx_sh_ff   <= 9'h1FF;
      crc_ff     <= 8'h00;
      unit_ff    <= 8'h00;
      rw_ff      <= 8'h00;
      data_ff    <= 32'h0000_0000;
      rd_data_ff <= 32'h0000_0000;
      bad_ff     <= 1'b0;
      tx_ff      <= 1'b1;
      oe_ff      <= 1'b0;
      valid_ff   <= 1'b0;
      err_ff     <= 1'b0;
    end else begin
      line_d_ff <= bus.line;
      valid_ff  <= 1'b0;
      err_ff    <= 1'b0;
      if (!tick) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      case (state_ff)
        swu_pkg::H_IDLE: begin
          // Sync byte needs no captured fields, so it loads in the same edge
          if (i_req) begin
            unit_ff  <= i_unit_addr;
            rw_ff    <= {i_write, i_reg_addr};
            data_ff  <= i_wr_data;
            bad_ff   <= 1'b0;
            tx_ff    <= 1'b0;
            oe_ff    <= 1'b1;
            tx_sh_ff <= {1'b1, tx_byte};
            crc_ff   <= crc_new;
            idx_ff   <= 3'h0;
            bitn_ff  <= 4'h0;
            cnt_ff   <= BIT_W - 1'b1;
            state_ff <= swu_pkg::H_SEND;
          end
        end
        swu_pkg::H_SEND: begin
          if (tick && bitn_ff != `SWU_TX_DONE_BIT) begin
            tx_ff    <= tx_sh_ff[0];
            tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
            bitn_ff  <= bitn_ff + 4'h1;
            cnt_ff   <= BIT_W - 1'b1;
          end else if (tick && idx_ff == last) begin
            oe_ff    <= 1'b0;
            idx_ff   <= 3'h0;
            crc_ff   <= 8'h00;
            cnt_ff   <= TW'(REPLY_BITS) * BIT_W - 1'b1;
            state_ff <= rw_ff[`SWU_RW_BIT] ? swu_pkg::H_IDLE : swu_pkg::H_WAIT;
          end else if (tick) begin
            tx_ff    <= 1'b0;
            tx_sh_ff <= {1'b1, tx_byte};
            crc_ff   <= crc_new;
            idx_ff   <= nidx;
            bitn_ff  <= 4'h0;
            cnt_ff   <= BIT_W - 1'b1;
          end
        end
        swu_pkg::H_WAIT: begin
          if (fall) begin
            cnt_ff   <= BIT_W + (BIT_W >> 1) - 1'b1;
            bitn_ff  <= 4'h0;
            state_ff <= swu_pkg::H_RECV;
          end else if (tick) begin
            err_ff   <= 1'b1;
            cnt_ff   <= guard_w;
            state_ff <= swu_pkg::H_GUARD;
          end
        end
        swu_pkg::H_RECV: begin
          if (tick && bitn_ff != `SWU_STOP_BIT) begin
            sh_ff   <= {bus.line, sh_ff[7:1]};
            bitn_ff <= bitn_ff + 4'h1;
            cnt_ff  <= BIT_W - 1'b1;
          end else if (tick && (!bus.line || (idx_ff == `SWU_WR_LAST
                                && (bad_ff || sh_ff != crc_ff)))) begin
            err_ff   <= 1'b1;
            cnt_ff   <= guard_w;
            state_ff <= swu_pkg::H_GUARD;
          end else if (tick && idx_ff == `SWU_WR_LAST) begin
            valid_ff   <= 1'b1;
            rd_data_ff <= data_ff;
            state_ff   <= swu_pkg::H_IDLE;
          end else if (tick) begin
            crc_ff   <= crc_new;
            idx_ff   <= idx_ff + 3'h1;
            cnt_ff   <= TW'(`SWU_TIMEOUT_BITS) * BIT_W - 1'b1;
            state_ff <= swu_pkg::H_WAIT;
            if ((idx_ff == 3'h0 && sh_ff[3:0] != 4'(`SWU_SYNC_BYTE))
                || (idx_ff == 3'h1 && sh_ff != `SWU_REPLY_ADDR)
                || (idx_ff == 3'h2 && sh_ff != {1'b0, rw_ff[6:0]})) begin
              bad_ff <= 1'b1;
            end
            if (idx_ff >= 3'h3) begin
              data_ff <= {data_ff[23:0], sh_ff};
            end
          end
        end
        swu_pkg::H_GUARD: begin
          // Line must stay idle a full guard span after any failure
          if (!bus.line) begin
            cnt_ff <= guard_w;
          end else if (tick) begin
            state_ff <= swu_pkg::H_IDLE;
          end
        end
        default: begin
          state_ff <= swu_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign bus.host_tx = tx_ff;
  assign bus.host_oe = oe_ff;
  assign o_busy      = ~idle;
  assign o_rd_valid  = valid_ff;
  assign o_rd_data   = rd_data_ff;
  assign o_rd_error  = err_ff;
endmodule : swu_host

// File: test/swu_link_checker.sv
`timescale 1ns/1ns
module swu_link_checker #(
  parameter int BT = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Link signals
  input wire logic i_dev_tx,
  input wire logic i_dev_oe,
  input wire logic i_host_tx,
  input wire logic i_host_oe,
  input wire logic i_line
);
  logic [11:0] oe_cnt_ff, hi_cnt_ff;
  logic [7:0]  ph_ff;
  if (BT != 16) begin : g_chk
    $error("sync sequence delays assume a bit time of 16");
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_cnt_ff <= 12'h000;
      hi_cnt_ff <= 12'h000;
      ph_ff     <= 8'h00;
    end else begin
      oe_cnt_ff <= i_dev_oe ? oe_cnt_ff + 12'h001 : 12'h000;
      hi_cnt_ff <= (i_dev_oe && i_dev_tx) ? hi_cnt_ff + 12'h001 : 12'h000;
      ph_ff     <= (i_dev_oe && ph_ff != 8'(BT - 1)) ? ph_ff + 8'h01 : 8'h00;
    end
  end
  // Mid-bit samples; plain delays tie this to a bit time of 16
  sequence s_sync(x);
    ##8 !x ##16 x ##16 !x ##16 x ##16 !x;
  endsequence
  AST_DEV_SYNC: assert property ($rose(i_dev_oe) |-> s_sync(i_dev_tx))
    else $error("reply lacks start bit and sync nibble");
  AST_HOST_SYNC: assert property ($rose(i_host_oe) |-> s_sync(i_host_tx))
    else $error("request lacks start bit and sync nibble");
  AST_BIT_EDGE: assert property (i_dev_oe && $past(i_dev_oe) && $changed(i_dev_tx)
    |-> ph_ff == 8'h00) else $error("reply bit edge off the request bit grid");
  AST_REPLY_LEN: assert property ($fell(i_dev_oe)
    |-> oe_cnt_ff inside {[84 * BT - 4 : 84 * BT + 4]}) else $error("reply length wrong");
  // High run may start inside the CRC byte, so it spans 5 to 13 bits
  AST_RELEASE: assert property ($fell(i_dev_oe)
    |-> hi_cnt_ff inside {[5 * BT - 4 : 13 * BT + 4]}) else $error("driver released early");
  AST_NO_CLASH: assert property (!(i_dev_oe && i_host_oe))
    else $error("both ends drive the line");
  AST_TURN_QUIET: assert property ($fell(i_host_oe) |-> !i_dev_oe throughout (##100 1'b1))
    else $error("device drives inside turnaround");
  AST_HOST_END: assert property ($fell(i_host_oe) |-> $past(i_line))
    else $error("host releases line while low");
endmodule : swu_link_checker

// File: test/testbench.sv
`timescale 1ns/1ns
`define SWU_CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
  localparam int BT = 16;
  logic        i_clk, i_reset_n, req, wr, pin_lo, pin_hi, busy, rd_valid, rd_err;
  logic        wr_stb, rd_stb, rx_err, rx_err2, dev_oe1;
  logic [7:0]  unit, wcount, wc;
  logic [6:0]  reg_a, wr_addr, rd_addr, ra;
  logic [31:0] wdat, rdd, rd_data, wr_data, seed, re;
  logic [38:0] we;
  logic [3:0]  tdel;
  logic [3:0]  dl[3] = '{4'h0, 4'h5, 4'hF};
  int          n_fail, check_count, n;
  logic [38:0] wq[$];
  logic [31:0] rq[$];
  swu_if if1 ();
  swu_if if2 ();
  assign dev_oe1 = if1.dev_oe;
  swu_device u_swu_device (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(if1.dev),
    .i_addr_select_pin_low(pin_lo), .i_addr_select_pin_high(pin_hi),
    .i_reply_turnaround_delay(tdel), .o_wr_strobe(wr_stb), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_strobe(rd_stb), .o_rd_addr(rd_addr), .i_rd_data(rdd),
    .o_write_count(wcount), .o_rx_error(rx_err));
  // Second device faces the bench, which breaks line rules on purpose
  swu_device u_swu_device_b (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(if2.dev),
    .i_addr_select_pin_low(pin_lo), .i_addr_select_pin_high(pin_hi),
    .i_reply_turnaround_delay(tdel), .o_wr_strobe(), .o_wr_addr(), .o_wr_data(),
    .o_rd_strobe(), .o_rd_addr(), .i_rd_data(rdd), .o_write_count(), .o_rx_error(rx_err2));
  swu_host #(.BIT_CYC(BT)) u_swu_host (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(if1.host),
    .i_req(req), .i_write(wr), .i_unit_addr(unit), .i_reg_addr(reg_a), .i_wr_data(wdat),
    .o_busy(busy), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_rd_error(rd_err));
  swu_link_checker #(.BT(BT)) u_swu_link_checker (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_dev_tx(if1.dev_tx), .i_dev_oe(if1.dev_oe), .i_host_tx(if1.host_tx),
    .i_host_oe(if1.host_oe), .i_line(if1.line));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic wait_for(ref logic s, input logic v, output int k);
    for (k = 0; k < 20000 && s !== v; k++) @(posedge i_clk);
    if (k == 20000) begin
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_for
  task automatic xfer(input logic w, input logic [7:0] u, input logic [31:0] d);
    int m;
    @(posedge i_clk);
    req   <= 1'b1;
    wr    <= w;
    unit  <= u;
    reg_a <= ra;
    wdat  <= d;
    @(posedge i_clk);
    req <= 1'b0;
    @(posedge i_clk);
    if (!w) begin
      wait_for(rd_stb, 1'b1, m);
      wait_for(dev_oe1, 1'b1, n);
    end
    wait_for(busy, 1'b0, m);
    // Device keeps driving four bit times past its reply
    if (!w) wait_for(dev_oe1, 1'b0, m);
  endtask : xfer
  always @(posedge i_clk) begin
    if (wr_stb === 1'b1 && wq.size() == 0) `SWU_CHK(wr_stb, 1'b0)
    else if (wr_stb === 1'b1) begin
      we = wq.pop_front();
      `SWU_CHK({wr_addr, wr_data}, we)
    end
    if (rd_valid === 1'b1 && rq.size() > 0) begin
      re = rq.pop_front();
      `SWU_CHK(rd_data, re)
    end else if (rd_valid === 1'b1) `SWU_CHK(rd_valid, 1'b0)
    if (rd_err === 1'b1) `SWU_CHK(rd_err, 1'b0)
    if (rx_err === 1'b1) `SWU_CHK(rx_err, 1'b0)
  end
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    {i_reset_n, req, wr, pin_lo, pin_hi, unit, reg_a, wdat, rdd, tdel, ra} = '0;
    {wc, n_fail, check_count} = '0;
    seed = 32'h0000_0038;
    if2.host_tx = 1'b1;
    if2.host_oe = 1'b0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    if2.host_oe <= 1'b1;
    if2.host_tx <= 1'b0;
    repeat (10) @(posedge i_clk);
    if2.host_oe <= 1'b0;
    if2.host_tx <= 1'b1;
    wait_for(rx_err2, 1'b1, n);
    `SWU_CHK(rx_err2, 1'b1)
    $display("glitch test done");
    for (int k = 0; k < 4; k++) begin
      pin_lo <= k[0];
      pin_hi <= k[1];
      seed = lfsr(seed);
      ra = seed[6:0];
      seed = lfsr(seed);
      wq.push_back({ra, seed});
      xfer(1'b1, {6'h00, k[1:0]}, seed);
      wc++;
      `SWU_CHK(wcount, wc)
    end
    xfer(1'b1, 8'h01, seed);
    `SWU_CHK(wcount, wc)
    $display("write test done");
    foreach (dl[i]) begin
      tdel <= dl[i];
      seed = lfsr(seed);
      rdd <= seed;
      rq.push_back(seed);
      ra = seed[14:8];
      xfer(1'b0, 8'h03, 32'h0000_0000);
      `SWU_CHK(rd_addr, ra)
      `SWU_CHK(n >= 8 * (dl[i] + 1) * BT - 3 && n <= 8 * (dl[i] + 1) * BT + 3, 1'b1)
      `SWU_CHK(wcount, wc)
    end
    `SWU_CHK(rq.size(), 0)
    $display("read test done");
    report_and_stop();
  end
endmodule : testbench
